// ==== common/flash_seq_pkg.sv ====
package flash_seq_pkg;

  // register byte offsets on the wishbone side
  localparam logic [7:0] OFF_LOWER_CTRL   = 8'h00;
  localparam logic [7:0] OFF_UPPER_CTRL   = 8'h04;
  localparam logic [7:0] OFF_ERASE_SEL_A  = 8'h08;
  localparam logic [7:0] OFF_ERASE_SEL_B  = 8'h0c;
  localparam logic [7:0] OFF_STATUS       = 8'h10;

  // bank control register bit positions
  localparam int BIT_PROG_PULSE   = 0;
  localparam int BIT_ERASE_PULSE  = 1;
  localparam int BIT_PROG_VERIFY  = 2;
  localparam int BIT_ERASE_VERIFY = 3;
  localparam int BIT_PROG_SETUP   = 4;
  localparam int BIT_ERASE_SETUP  = 5;
  localparam int BIT_SW_ENABLE    = 6;
  localparam int CTRL_W           = 7;

  // status register bit positions
  localparam int ST_PERMIT        = 0;
  localparam int ST_LOWER_PROG    = 1;
  localparam int ST_LOWER_ERASE   = 2;
  localparam int ST_UPPER_PROG    = 3;
  localparam int ST_UPPER_ERASE   = 4;
  localparam int ST_READ_BLOCKED  = 5;
  localparam int ST_COUNT_LSB     = 8;

  // reset values and the word returned by blocked reads
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [7:0]        SEL_RESET  = 8'h00;
  localparam logic [15:0]       BLOCKED_READ = 16'hffff;

  // array address map
  localparam int ADDR_W      = 19;
  localparam int PAGE_BYTES  = 128;
  localparam int PAGE_IDX_W  = 7;
  localparam logic [ADDR_W-1:0] LOWER_LAST = 19'h3ffff;
  localparam logic [ADDR_W-1:0] UPPER_LAST = 19'h47fff;

  typedef struct packed {
    logic sw_enable;
    logic programming;
    logic erasing;
    logic verifying;
  } bank_mode_s;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } flash_req_s;

endpackage : flash_seq_pkg

// ==== core/bank_ctrl_reg.sv ====
`timescale 1ns/1ps
module bank_ctrl_reg
  import flash_seq_pkg::*;
(
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                rstn_i,
  // register write
  input  wire logic                wr_i,
  input  wire logic [CTRL_W-1:0]   wdata_i,
  input  wire logic                permit_i,
  // state
  output logic      [CTRL_W-1:0]   ctrl_o,
  output flash_seq_pkg::bank_mode_s mode_o
);
  import flash_seq_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (!permit_i) begin
      // permit pin low wipes the bits so nothing resumes on its return
      nxt_state.ctrl = CTRL_RESET;
    end else if (wr_i) begin
      nxt_state.ctrl = wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '{ctrl: CTRL_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ctrl_o = state_ff.ctrl;
  assign mode_o.sw_enable   = state_ff.ctrl[BIT_SW_ENABLE] & permit_i;
  // pulse lasts exactly as long as the pulse bit stays set together with the enable and setup bits and the synchronised permit
  assign mode_o.programming = permit_i & state_ff.ctrl[BIT_SW_ENABLE] & state_ff.ctrl[BIT_PROG_SETUP]
                              & state_ff.ctrl[BIT_PROG_PULSE];
  assign mode_o.erasing     = permit_i & state_ff.ctrl[BIT_SW_ENABLE] & state_ff.ctrl[BIT_ERASE_SETUP]
                              & state_ff.ctrl[BIT_ERASE_PULSE];
  assign mode_o.verifying   = state_ff.ctrl[BIT_SW_ENABLE]
                              & (state_ff.ctrl[BIT_PROG_VERIFY] | state_ff.ctrl[BIT_ERASE_VERIFY]);

endmodule : bank_ctrl_reg

// ==== core/flash_program_erase_sequencer.sv ====
`timescale 1ns/1ps
// Contract
// - lower bank addresses use the lower control register, upper bank the upper one.
// - normal reads of a bank under program or erase return no array data.
// - program and erase never happen while the write permit pin is low; the code stops them four clock edges after the pin falls, and ignores a low of one cycle.
// - 128 byte writes from a 128-aligned start are latched as address and data.
// - setup, 50 us wait, pulse bit; programming lasts while pulse bit set.
// - verify dummy write latches address; word read returns that address's data.
// - erase setup, 100 us wait, pulse bit; erase while set, at most 10 ms.
// - whole array unreadable while lower bank software enable is set; the code still passes verify reads of a verifying bank.
module flash_program_erase_sequencer
  import flash_seq_pkg::*;
(
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rstn_i,
  // wishbone register slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // write permit pin
  input  wire logic                        flash_write_permit_pin_i,
  // cpu access to the flash address space
  input  flash_seq_pkg::flash_req_s        flash_req_i,
  output logic      [15:0]                 flash_rdata_o,
  output logic                             flash_rvalid_o,
  // array macro side
  output logic      [flash_seq_pkg::ADDR_W-1:0] arr_addr_o,
  input  wire logic [15:0]                 arr_rdata_i,
  input  wire logic [flash_seq_pkg::PAGE_IDX_W-1:0] page_idx_i,
  output logic      [7:0]                  page_byte_o,
  output logic      [1:0]                  prog_pulse_o,
  output logic      [1:0]                  erase_pulse_o,
  output logic      [15:0]                 erase_blocks_o
);
  import flash_seq_pkg::*;

  typedef struct packed {
    logic [2:0]                       permit_sync;
    logic                             permit;
    logic                             ack;
    logic [31:0]                      rdat;
    logic [7:0]                       sel_a;
    logic [7:0]                       sel_b;
    logic [PAGE_BYTES-1:0][7:0]       page;
    logic [7:0]                       page_cnt;
    logic [ADDR_W-1:0]                latch_addr;
    logic [ADDR_W-1:0]                arr_addr;
    logic                             rd_pend;
    logic                             rd_blocked;
    logic                             last_blocked;
    logic [15:0]                      rdata;
    logic                             rvalid;
    logic [7:0]                       page_byte;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  logic [CTRL_W-1:0] lower_ctrl;
  logic [CTRL_W-1:0] upper_ctrl;
  bank_mode_s        lower_mode;
  bank_mode_s        upper_mode;
  logic              bus_req;
  logic              bus_wr;
  logic              req_lower;
  logic              req_upper;
  bank_mode_s        req_mode;
  logic              req_busy;
  logic [31:0]       status_word;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where ack is seen, as the master expects
  assign bus_wr  = bus_req & wb_we_i & state_ff.ack & wb_sel_i[0];

  bank_ctrl_reg u_lower_ctrl (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .wr_i     (bus_wr && wb_adr_i == OFF_LOWER_CTRL),
    .wdata_i  (wb_dat_i[CTRL_W-1:0]),
    .permit_i (state_ff.permit),
    .ctrl_o   (lower_ctrl),
    .mode_o   (lower_mode)
  );

  bank_ctrl_reg u_upper_ctrl (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .wr_i     (bus_wr && wb_adr_i == OFF_UPPER_CTRL),
    .wdata_i  (wb_dat_i[CTRL_W-1:0]),
    .permit_i (state_ff.permit),
    .ctrl_o   (upper_ctrl),
    .mode_o   (upper_mode)
  );

  // address decode into banks
  assign req_lower = flash_req_i.addr <= LOWER_LAST;
  assign req_upper = (flash_req_i.addr > LOWER_LAST) && (flash_req_i.addr <= UPPER_LAST);

  always_comb begin
    req_mode = '0;
    if (req_lower) begin
      req_mode = lower_mode;
    end else if (req_upper) begin
      req_mode = upper_mode;
    end
  end

  // lower enable hides the whole array, but a verifying bank must still answer its verify reads
  assign req_busy = (lower_mode.sw_enable & ~req_mode.verifying)
                    | ((req_lower | req_upper) & (req_mode.programming | req_mode.erasing));

  always_comb begin
    status_word = '0;
    status_word[ST_PERMIT]       = state_ff.permit;
    status_word[ST_LOWER_PROG]   = lower_mode.programming;
    status_word[ST_LOWER_ERASE]  = lower_mode.erasing;
    status_word[ST_UPPER_PROG]   = upper_mode.programming;
    status_word[ST_UPPER_ERASE]  = upper_mode.erasing;
    status_word[ST_READ_BLOCKED] = state_ff.last_blocked;
    status_word[ST_COUNT_LSB +: 8] = state_ff.page_cnt;
  end

  always_comb begin
    nxt_state = state_ff;

    // permit pin: three stages, a change counts once the last two agree
    nxt_state.permit_sync = {state_ff.permit_sync[1:0], flash_write_permit_pin_i};
    if (state_ff.permit_sync[1] == state_ff.permit_sync[2]) begin
      nxt_state.permit = state_ff.permit_sync[2];
    end

    // wishbone: answer one cycle after the request, drop the cycle after
    nxt_state.ack = bus_req & ~state_ff.ack;
    if (bus_req && !state_ff.ack) begin
      unique case (wb_adr_i)
        OFF_LOWER_CTRL:  nxt_state.rdat = {25'h0000000, lower_ctrl};
        OFF_UPPER_CTRL:  nxt_state.rdat = {25'h0000000, upper_ctrl};
        OFF_ERASE_SEL_A: nxt_state.rdat = {24'h000000, state_ff.sel_a};
        OFF_ERASE_SEL_B: nxt_state.rdat = {24'h000000, state_ff.sel_b};
        OFF_STATUS:      nxt_state.rdat = status_word;
        default:         nxt_state.rdat = 32'h00000000;
      endcase
    end
    if (bus_wr && wb_adr_i == OFF_ERASE_SEL_A) begin
      nxt_state.sel_a = wb_dat_i[7:0];
    end
    if (bus_wr && wb_adr_i == OFF_ERASE_SEL_B) begin
      nxt_state.sel_b = wb_dat_i[7:0];
    end
    if (!state_ff.permit) begin
      nxt_state.sel_a = SEL_RESET;
      nxt_state.sel_b = SEL_RESET;
    end

    // byte writes into the flash space
    if (flash_req_i.wr && req_mode.sw_enable) begin
      nxt_state.latch_addr = flash_req_i.addr;
      if (!req_mode.verifying && !req_mode.programming && !req_mode.erasing) begin
        // index from the low seven address bits, so a 128-aligned run fills the page
        nxt_state.page[flash_req_i.addr[PAGE_IDX_W-1:0]] = flash_req_i.wdata;
        if (flash_req_i.addr[PAGE_IDX_W-1:0] == 7'h00) begin
          nxt_state.page_cnt = 8'h01;
        end else begin
          nxt_state.page_cnt = state_ff.page_cnt + 8'h01;
        end
      end
    end

    // reads: address the array, take its word on the next cycle
    nxt_state.rvalid  = 1'b0;
    nxt_state.rd_pend = 1'b0;
    if (flash_req_i.rd) begin
      nxt_state.rd_pend    = 1'b1;
      nxt_state.rd_blocked = req_busy;
      // in verify the word comes from the latched address, not the bus
      nxt_state.arr_addr   = req_mode.verifying ? state_ff.latch_addr : flash_req_i.addr;
    end else if (flash_req_i.wr && req_mode.sw_enable) begin
      nxt_state.arr_addr = flash_req_i.addr;
    end
    if (state_ff.rd_pend) begin
      nxt_state.rvalid       = 1'b1;
      nxt_state.last_blocked = state_ff.rd_blocked;
      nxt_state.rdata        = state_ff.rd_blocked ? BLOCKED_READ : arr_rdata_i;
    end

    nxt_state.page_byte = state_ff.page[page_idx_i];
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wb_ack_o       = state_ff.ack;
  assign wb_dat_o       = state_ff.rdat;
  assign flash_rdata_o  = state_ff.rdata;
  assign flash_rvalid_o = state_ff.rvalid;
  assign arr_addr_o     = state_ff.arr_addr;
  assign page_byte_o    = state_ff.page_byte;
  assign prog_pulse_o   = {upper_mode.programming, lower_mode.programming};
  assign erase_pulse_o  = {upper_mode.erasing, lower_mode.erasing};
  assign erase_blocks_o = (lower_mode.erasing | upper_mode.erasing) ? {state_ff.sel_b, state_ff.sel_a} : 16'h0000;

endmodule : flash_program_erase_sequencer

// ==== test/flash_seq_assertions.sv ====
`timescale 1ns/1ps
module flash_seq_assertions
  import flash_seq_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // observed ports
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic        wb_ack_o,
  input  wire logic        flash_write_permit_pin_i,
  input  flash_seq_pkg::flash_req_s flash_req_i,
  input  wire logic        flash_rvalid_o,
  input  wire logic [1:0]  prog_pulse_o,
  input  wire logic [1:0]  erase_pulse_o,
  input  wire logic [15:0] erase_blocks_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // five samples cover the pin synchroniser depth
  permit_low_idle_a: assert property (
    !flash_write_permit_pin_i [*5] |-> prog_pulse_o == 2'h0 && erase_pulse_o == 2'h0)
    else $error("pulse while permit pin low");
  lower_prog_src_a: assert property (
    $rose(prog_pulse_o[0]) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == OFF_LOWER_CTRL))
    else $error("lower program pulse without lower write");
  upper_prog_src_a: assert property (
    $rose(prog_pulse_o[1]) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == OFF_UPPER_CTRL))
    else $error("upper program pulse without upper write");
  lower_erase_src_a: assert property (
    $rose(erase_pulse_o[0]) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == OFF_LOWER_CTRL))
    else $error("lower erase pulse without lower write");
  upper_erase_src_a: assert property (
    $rose(erase_pulse_o[1]) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == OFF_UPPER_CTRL))
    else $error("upper erase pulse without upper write");
  read_answer_a: assert property (flash_req_i.rd |-> ##2 flash_rvalid_o)
    else $error("flash read not answered in two cycles");
  read_cause_a: assert property (flash_rvalid_o |-> $past(flash_req_i.rd, 2))
    else $error("read valid without read");
  erase_blocks_idle_a: assert property (erase_pulse_o == 2'h0 |-> erase_blocks_o == 16'h0)
    else $error("erase blocks shown outside erase");
endmodule : flash_seq_assertions

// ==== test/flash_program_erase_sequencer_tb.sv ====
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb;
  import flash_seq_pkg::*;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        permit = 1'b1;
  flash_req_s  flash_req_i = '0;
  logic [15:0] flash_rdata_o;
  logic        flash_rvalid_o;
  logic [18:0] arr_addr_o;
  logic [6:0]  page_idx_i = 7'h00;
  logic [7:0]  page_byte_o;
  logic [1:0]  prog_pulse_o;
  logic [1:0]  erase_pulse_o;
  logic [15:0] erase_blocks_o;
  logic [31:0] q;
  logic [31:0] rnd = 32'hb791;
  logic [18:0] a;
  logic [7:0]  sel;
  logic [7:0]  pg [128];
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          i;
  always #50 clock_i = ~clock_i;
  flash_program_erase_sequencer u_flash_program_erase_sequencer (
    .clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_write_permit_pin_i(permit),
    .flash_req_i(flash_req_i), .flash_rdata_o(flash_rdata_o), .flash_rvalid_o(flash_rvalid_o),
    .arr_addr_o(arr_addr_o), .arr_rdata_i(arr_addr_o[15:0] ^ 16'ha5c3), .page_idx_i(page_idx_i),
    .page_byte_o(page_byte_o), .prog_pulse_o(prog_pulse_o), .erase_pulse_o(erase_pulse_o),
    .erase_blocks_o(erase_blocks_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] arr_word(input logic [18:0] x);
    return x[15:0] ^ 16'ha5c3;
  endfunction : arr_word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock_i);
  endtask : wb
  task automatic freq(input logic rd, input logic [18:0] ad, input logic [7:0] d);
    flash_req_i <= '{rd: rd, wr: !rd, addr: ad, wdata: d};
    @(posedge clock_i);
    flash_req_i <= '0;
    @(posedge clock_i);
  endtask : freq
  task automatic frd(input logic [18:0] ad, input logic [15:0] exp);
    freq(1'b1, ad, 8'h00);
    @(posedge clock_i);
    chk({31'h0, flash_rvalid_o}, 32'h1);
    chk({16'h0, flash_rdata_o}, {16'h0, exp});
  endtask : frd
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    // control, select and an unmapped hole all read zero
    for (i = 0; i < 24; i += 4) begin
      if (i != 16) begin
        wb(1'b0, 8'(i), 32'h0);
        chk(q, 32'h0);
      end
    end
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = rnd[20] ? {4'h8, rnd[14:0]} : {1'b0, rnd[17:0]};
      frd(a, arr_word(a));
    end
    wb(1'b1, OFF_UPPER_CTRL, 32'h40);
    repeat (10) @(posedge clock_i);
    for (i = 0; i < 128; i++) begin
      rnd = lfsr(rnd);
      pg[i] = rnd[7:0];
      freq(1'b0, 19'h40080 + 19'(i), pg[i]);
    end
    for (i = 0; i < 128; i++) begin
      page_idx_i <= 7'(i);
      repeat (3) @(posedge clock_i);
      chk({24'h0, page_byte_o}, {24'h0, pg[i]});
    end
    wb(1'b1, OFF_UPPER_CTRL, 32'h50);
    repeat (500) @(posedge clock_i);
    wb(1'b1, OFF_UPPER_CTRL, 32'h51);
    chk({30'h0, prog_pulse_o}, 32'h2);
    frd(19'h40080, 16'hffff);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(q, (32'h1 << ST_PERMIT) | (32'h1 << ST_UPPER_PROG) | (32'h1 << ST_READ_BLOCKED) | (32'(PAGE_BYTES) << ST_COUNT_LSB));
    frd(19'h01234, arr_word(19'h01234));
    repeat (300) @(posedge clock_i);
    wb(1'b1, OFF_UPPER_CTRL, 32'h50);
    chk({30'h0, prog_pulse_o}, 32'h0);
    repeat (50) @(posedge clock_i);
    wb(1'b1, OFF_UPPER_CTRL, 32'h44);
    repeat (40) @(posedge clock_i);
    freq(1'b0, 19'h40100, 8'hff);
    repeat (20) @(posedge clock_i);
    frd(19'h40200, arr_word(19'h40100));
    wb(1'b1, OFF_UPPER_CTRL, 32'h40);
    repeat (20) @(posedge clock_i);
    wb(1'b1, OFF_UPPER_CTRL, 32'h00);
    wb(1'b1, OFF_LOWER_CTRL, 32'h40);
    frd(19'h40010, 16'hffff);
    rnd = lfsr(rnd);
    sel = 8'h01 << rnd[2:0];
    wb(1'b1, OFF_ERASE_SEL_A, {24'h0, sel});
    wb(1'b1, OFF_LOWER_CTRL, 32'h60);
    repeat (1000) @(posedge clock_i);
    wb(1'b1, OFF_LOWER_CTRL, 32'h62);
    chk({30'h0, erase_pulse_o}, 32'h1);
    chk({16'h0, erase_blocks_o}, {24'h0, sel});
    // drop the permit pin in mid-erase
    permit <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk({30'h0, erase_pulse_o}, 32'h0);
    wb(1'b1, OFF_LOWER_CTRL, 32'h51);
    chk({30'h0, prog_pulse_o}, 32'h0);
    wb(1'b0, OFF_LOWER_CTRL, 32'h0);
    chk(q, 32'h0);
    permit <= 1'b1;
    repeat (6) @(posedge clock_i);
    // lower erase verify: verify reads pass even with the lower enable set
    wb(1'b1, OFF_LOWER_CTRL, 32'h48);
    repeat (60) @(posedge clock_i);
    freq(1'b0, 19'h00200, 8'hff);
    repeat (20) @(posedge clock_i);
    frd(19'h00300, arr_word(19'h00200));
    wb(1'b1, OFF_LOWER_CTRL, 32'h40);
    repeat (40) @(posedge clock_i);
    wb(1'b1, OFF_LOWER_CTRL, 32'h00);
    stop_test();
  end
endmodule : flash_program_erase_sequencer_tb
bind flash_program_erase_sequencer flash_seq_assertions u_flash_seq_assertions (
  .clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .flash_write_permit_pin_i(flash_write_permit_pin_i), .flash_req_i(flash_req_i),
  .flash_rvalid_o(flash_rvalid_o), .prog_pulse_o(prog_pulse_o),
  .erase_pulse_o(erase_pulse_o), .erase_blocks_o(erase_blocks_o));
